// ===== pkg/lcr_pkg.sv
package lcr_pkg;

  // register map
  localparam logic [11:0] LCR_LINK_CAP_OFFSET   = 12'h04c;
  localparam logic [11:0] LCR_UNLOCK_CTL_OFFSET = 12'h100;
  localparam logic [11:0] LCR_CLOCK_CTL_OFFSET  = 12'h104;
  localparam logic [11:0] LCR_EFF_WIDTH_OFFSET  = 12'h108;

  // field positions
  localparam int LCR_SPEED_LSB  = 0;
  localparam int LCR_WIDTH_LSB  = 4;
  localparam int LCR_PSS_LSB    = 10;
  localparam int LCR_L0S_LSB    = 12;
  localparam int LCR_L1_LSB     = 15;
  localparam int LCR_CPM_BIT    = 18;
  localparam int LCR_SURPRISE_DOWN_CAP_BIT  = 19;
  localparam int LCR_LACT_BIT   = 20;
  localparam int LCR_BWN_BIT    = 21;
  localparam int LCR_PORT_LSB   = 24;

  // field values
  localparam logic [3:0] LCR_SPEED_GEN1   = 4'h1;
  localparam logic [1:0] LCR_PSS_L0S_L1   = 2'h3;
  localparam logic [2:0] LCR_L0S_SEPARATE = 3'h5;
  localparam logic [2:0] LCR_L0S_COMMON   = 3'h3;
  localparam logic [2:0] LCR_L1_DEFAULT   = 3'h2;
  localparam logic       LCR_CPM_DEFAULT  = 1'b0;
  localparam logic [5:0] LCR_WIDTH_X1     = 6'h01;
  localparam logic [5:0] LCR_WIDTH_RESET  = 6'h01;
  localparam logic [7:0] LCR_PORT_MAX     = 8'h05;

  // edges a strap needs to reach the second synchroniser stage
  localparam logic [1:0] LCR_STRAP_SETTLE = 2'h2;

  localparam logic [31:0] LCR_ZERO_WORD = 32'h0000_0000;

endpackage : lcr_pkg

// ===== src/lcr_link_cap.sv
`timescale 1ns/1ps

module lcr_link_cap (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // port straps, static after reset
  input  wire logic [2:0]  port_index,
  input  wire logic [5:0]  port_lanes,
  input  wire logic        pcie11_mode,
  // effective width for link training
  output logic      [5:0]  train_width
);
  import lcr_pkg::*;

  // all state of the block; strap copies, lockable fields, bus answer
  typedef struct packed {
    // strap load bookkeeping
    logic        init_done;
    logic [1:0]  settle;
    // captured port identity, lockable fields, unlock and clock controls, training width
    logic [2:0]  port;
    logic [5:0]  width;
    logic [2:0]  l1_lat;
    logic        ref_clock_removal_cap;
    logic        surprise_down_cap;
    logic        lact;
    logic        bwn;
    logic        unlock;
    logic        shared_refclk_setting;
    logic [5:0]  train;
    // registered bus answer
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    // two-stage synchronisers for the straps
    logic [2:0]  idx_s1;
    logic [2:0]  idx_s2;
    logic [5:0]  ln_s1;
    logic [5:0]  ln_s2;
    logic        m11_s1;
    logic        m11_s2;
  } lcr_state_type;

  lcr_state_type s_q;
  lcr_state_type s_d;

  function automatic logic lcr_width_valid(input logic [5:0] w);
    case (w)
      6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20: lcr_width_valid = 1'b1;
      default:                                          lcr_width_valid = 1'b0;
    endcase
  endfunction : lcr_width_valid

  function automatic logic [31:0] lcr_cap_word(input lcr_state_type s);
    logic [31:0] w;
    w = LCR_ZERO_WORD;
    w[LCR_SPEED_LSB +: 4] = LCR_SPEED_GEN1;
    w[LCR_WIDTH_LSB +: 6] = s.width;
    w[LCR_PSS_LSB +: 2]   = LCR_PSS_L0S_L1;
    w[LCR_L0S_LSB +: 3]   = s.shared_refclk_setting ? LCR_L0S_COMMON
                                                    : LCR_L0S_SEPARATE;
    w[LCR_L1_LSB +: 3]    = s.l1_lat;
    w[LCR_CPM_BIT]        = s.ref_clock_removal_cap;
    w[LCR_SURPRISE_DOWN_CAP_BIT]      = s.surprise_down_cap;
    w[LCR_LACT_BIT]       = s.lact;
    w[LCR_BWN_BIT]        = s.bwn;
    w[LCR_PORT_LSB +: 8]  = {5'h00, s.port};
    lcr_cap_word = w;
  endfunction : lcr_cap_word

  // register selected by the current address
  typedef enum logic [2:0] {
    LCR_SEL_CAP,
    LCR_SEL_UNLOCK,
    LCR_SEL_CLOCK,
    LCR_SEL_WIDTH,
    LCR_SEL_NONE
  } lcr_sel_type;

  // one decode shared by the read half and the write half of an access
  function automatic lcr_sel_type lcr_addr_sel(input logic [11:0] a);
    lcr_sel_type sel;
    if (a == LCR_LINK_CAP_OFFSET) begin
      sel = LCR_SEL_CAP;
    end else if (a == LCR_UNLOCK_CTL_OFFSET) begin
      sel = LCR_SEL_UNLOCK;
    end else if (a == LCR_CLOCK_CTL_OFFSET) begin
      sel = LCR_SEL_CLOCK;
    end else if (a == LCR_EFF_WIDTH_OFFSET) begin
      sel = LCR_SEL_WIDTH;
    end else begin
      sel = LCR_SEL_NONE;
    end
    lcr_addr_sel = sel;
  endfunction : lcr_addr_sel

  // strap codes 6 and 7 have no port behind them; report the last port
  function automatic logic [2:0] lcr_clamp_port(input logic [2:0] idx);
    logic [2:0] p;
    p = idx;
    if ({5'h00, idx} > LCR_PORT_MAX) begin
      p = LCR_PORT_MAX[2:0];
    end
    lcr_clamp_port = p;
  endfunction : lcr_clamp_port

  // power-on defaults, taken from the settled straps exactly once
  function automatic lcr_state_type lcr_strap_load(input lcr_state_type s);
    lcr_state_type n;
    logic          up;
    n           = s;
    up          = (s.idx_s2 == 3'h0);
    n.init_done = 1'b1;
    n.port      = lcr_clamp_port(s.idx_s2);
    n.width     = s.ln_s2;
    n.l1_lat    = LCR_L1_DEFAULT;
    n.ref_clock_removal_cap       = LCR_CPM_DEFAULT;
    n.surprise_down_cap     = !up;
    n.lact      = !up;
    n.bwn       = !up && !s.m11_s2;
    lcr_strap_load = n;
  endfunction : lcr_strap_load

  // lockable fields; only called while the unlock control is set
  function automatic lcr_state_type lcr_cap_write(input lcr_state_type s,
                                                  input logic [31:0]   d,
                                                  input logic [3:0]    be);
    lcr_state_type n;
    logic          up;
    n  = s;
    up = (s.port == 3'h0);
    if (be[0]) begin
      n.width[3:0] = d[LCR_WIDTH_LSB +: 4];
    end
    if (be[1]) begin
      n.width[5:4] = d[LCR_WIDTH_LSB + 4 +: 2];
      n.l1_lat[0]  = d[LCR_L1_LSB];
    end
    if (be[2]) begin
      n.l1_lat[2:1] = d[LCR_L1_LSB + 1 +: 2];
      n.ref_clock_removal_cap         = d[LCR_CPM_BIT];
      n.surprise_down_cap       = d[LCR_SURPRISE_DOWN_CAP_BIT];
      // the upstream port has no link-active reporting, so it stays clear
      n.lact        = d[LCR_LACT_BIT] && !up;
      n.bwn         = d[LCR_BWN_BIT];
    end
    lcr_cap_write = n;
  endfunction : lcr_cap_write

  // read value of the selected register; unmapped space reads zero
  function automatic logic [31:0] lcr_read_word(input lcr_state_type s,
                                                input lcr_sel_type   sel);
    logic [31:0] w;
    w = LCR_ZERO_WORD;
    case (sel)
      LCR_SEL_CAP:    w = lcr_cap_word(s);
      LCR_SEL_UNLOCK: w = {31'h0000_0000, s.unlock};
      LCR_SEL_CLOCK:  w = {31'h0000_0000, s.shared_refclk_setting};
      LCR_SEL_WIDTH:  w = {26'h000_0000, s.train};
      default:        w = LCR_ZERO_WORD;
    endcase
    lcr_read_word = w;
  endfunction : lcr_read_word

  lcr_sel_type sel;
  logic        acc;
  logic        first_acc;
  logic        last_acc;

  // access timing: setup cycle, then two access cycles. the answer is
  // decoded in the first access cycle and registered, so prdata and
  // pslverr stand in the very cycle in which pready is high. writes
  // are applied in the second access cycle, at the edge where the
  // master samples pready, and at no other edge.
  always_comb begin
    s_d       = s_q;
    sel       = lcr_addr_sel(paddr);
    acc       = psel && penable;
    first_acc = acc && !s_q.ready;
    last_acc  = acc && s_q.ready;

    // the second stage leaves reset at zero, so the load waits until it
    // holds a real strap value; loading early would make every port
    // look like the upstream one
    if (!s_q.init_done) begin
      if (s_q.settle == LCR_STRAP_SETTLE) begin
        s_d = lcr_strap_load(s_q);
      end else begin
        s_d.settle = 2'(s_q.settle + 2'h1);
      end
    end

    // two-stage synchronisers for the straps
    s_d.idx_s1 = port_index;
    s_d.idx_s2 = s_q.idx_s1;
    s_d.ln_s1  = port_lanes;
    s_d.ln_s2  = s_q.ln_s1;
    s_d.m11_s1 = pcie11_mode;
    s_d.m11_s2 = s_q.m11_s1;

    // answer half: one wait state, pready pulses for one cycle
    s_d.ready = first_acc;
    s_d.err   = first_acc && (sel == LCR_SEL_NONE);
    s_d.rdata = LCR_ZERO_WORD;
    if (first_acc && !pwrite) begin
      s_d.rdata = lcr_read_word(s_q, sel);
    end

    // write half: unmapped and read-only addresses take no effect
    if (last_acc && pwrite) begin
      if (sel == LCR_SEL_CAP) begin
        if (s_q.unlock) begin
          s_d = lcr_cap_write(s_d, pwdata, pstrb);
        end
      end else if (sel == LCR_SEL_UNLOCK) begin
        if (pstrb[0]) begin
          s_d.unlock = pwdata[0];
        end
      end else if (sel == LCR_SEL_CLOCK) begin
        if (pstrb[0]) begin
          s_d.shared_refclk_setting = pwdata[0];
        end
      end
    end

    // link training sees x1 for any reserved width code
    s_d.train = lcr_width_valid(s_q.width) ? s_q.width : LCR_WIDTH_X1;
  end

  // reset gives width and train the x1 value, so link training never
  // sees a reserved code before the straps are loaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.width  <= LCR_WIDTH_RESET;
      s_q.train  <= LCR_WIDTH_X1;
      s_q.l1_lat <= LCR_L1_DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata      = s_q.rdata;
  assign pready      = s_q.ready;
  assign pslverr     = s_q.err;
  assign train_width = s_q.train;

endmodule : lcr_link_cap

// ===== tb/lcr_link_cap_properties.sv
`timescale 1ns/1ps
module lcr_link_cap_properties import lcr_pkg::*; (
  // apb side and width
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [5:0]  train_width
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic done_rd;
  logic cap_rd;
  assign done_rd = psel && penable && pready && !pwrite;
  assign cap_rd = done_rd && paddr == LCR_LINK_CAP_OFFSET;
  a_speed_code: assert property (cap_rd |-> prdata[3:0] == LCR_SPEED_GEN1) else $error("speed");
  a_pss_fixed: assert property (cap_rd |-> prdata[11:10] == LCR_PSS_L0S_L1) else $error("pss");
  a_l0s_code: assert property (cap_rd |-> prdata[14:12] inside {3'h3, 3'h5}) else $error("l0s");
  a_port_range: assert property (cap_rd |-> prdata[31:24] <= LCR_PORT_MAX) else $error("port");
  a_rsv_zero: assert property (cap_rd |-> prdata[23:22] == 2'h0) else $error("reserved");
  a_up_inactive: assert property (cap_rd && prdata[31:24] == 8'h00 |-> !prdata[20]) else $error("la");
  a_width_legal: assert property (train_width inside {1, 2, 4, 8, 12, 16, 32}) else $error("width");
  a_width_mirror: assert property (done_rd && paddr == LCR_EFF_WIDTH_OFFSET
    |-> prdata[5:0] == train_width) else $error("mirror");
  cover property (cap_rd && prdata[21]);
  cover property (cap_rd && prdata[14:12] == LCR_L0S_COMMON);
  cover property (train_width == LCR_WIDTH_X1 && $past(train_width) != LCR_WIDTH_X1);
endmodule : lcr_link_cap_properties
bind lcr_link_cap lcr_link_cap_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .train_width);

// ===== tb/lcr_link_cap_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module lcr_link_cap_tb;
  import lcr_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pcie11_mode = 0;
  logic pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] port_index = 3'h0;
  logic [5:0] port_lanes = 6'h08, train_width;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  lcr_link_cap dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_index(port_index), .port_lanes(port_lanes),
    .pcie11_mode(pcie11_mode), .train_width(train_width));
  initial forever #2.5 pclk = ~pclk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // straps only load after reset, so each port flavour needs its own reset
  task automatic rst(input logic [2:0] idx, input logic [5:0] lanes, input logic m);
    presetn <= 1'b0;
    port_index <= idx;
    port_lanes <= lanes;
    pcie11_mode <= m;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : rst
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    rst(3'h0, 6'h08, 1'b0);
    xfer(0, LCR_LINK_CAP_OFFSET, 0);
    `CHK(rdat, 32'h0001_5c81)
    xfer(1, LCR_LINK_CAP_OFFSET, 32'h0000_0020);
    xfer(0, LCR_LINK_CAP_OFFSET, 0);
    `CHK(rdat, 32'h0001_5c81)
    xfer(1, LCR_UNLOCK_CTL_OFFSET, 32'h0000_0001);
    xfer(1, LCR_LINK_CAP_OFFSET, 32'hffd1_5c21);
    xfer(0, LCR_LINK_CAP_OFFSET, 0);
    `CHK(rdat, 32'h0001_5c21)
    `CHK(train_width, 6'h02)
    xfer(1, LCR_LINK_CAP_OFFSET, 32'h0001_5c31);
    xfer(0, LCR_EFF_WIDTH_OFFSET, 0);
    `CHK(rdat[5:0], LCR_WIDTH_X1)
    xfer(1, LCR_CLOCK_CTL_OFFSET, 32'h0000_0001);
    xfer(0, LCR_LINK_CAP_OFFSET, 0);
    `CHK(rdat, 32'h0001_3c31)
    xfer(0, 12'h200, 0);
    `CHK(err, 1'b1)
    rst(3'h3, 6'h04, 1'b0);
    xfer(0, LCR_LINK_CAP_OFFSET, 0);
    `CHK(rdat, 32'h0339_5c41)
    rst(3'h7, 6'h10, 1'b1);
    xfer(0, LCR_LINK_CAP_OFFSET, 0);
    `CHK(rdat, 32'h0519_5d01)
    summarize();
  end
endmodule : lcr_link_cap_tb
